// ---- rtl/asrc_host.sv ----
// host controller driving an asynchronous 2K x 8 static memory over its pins
// Contract
// RL1: memory holds 2048 bytes, eleven-bit address, one shared byte bus.
// RL2: select high puts memory into standby until select low again.
// RL3: select high means standby and floating bus, other pins ignored.
// RL4: write happens only during overlap of select low and strobe low.
// RL5: address changes only while strobe high or select high.
// RL6: write recovery counts from first of select or strobe rising.
// RL7: select falling with or after strobe keeps memory outputs floating.
// RL8: strobe write with enable low: strobe low max of pulse, float+overlap.
// RL9: select-controlled write may keep enable low without longer select time.
// RL10: host never drives data while memory still drives the bus.
// RL11: write data held stable at least hold time after write end.
// RL12: memory data hold is shorter than its output re-drive delay.
// RL13: read keeps strobe high, address valid by select falling edge.
// RL14: reads spaced by read cycle time; data valid after address access.
// RL15: read data valid within select access time after select falls.
// RL16: read data valid within 10 ns after enable falls.
// RL17: previous data held 5 ns after address change.
// RL18: outputs drive 5 ns after select falls, float 10 ns after rise.
// RL19: memory powers down within 15 ns after select rises.
// RL20: address valid 14 ns and select low 13 ns before write end.
// RL21: strobe low at least 12 ns, data valid 12 ns before end.
// RL22: memory floats 7 ns after strobe falls, re-drives after write end.
// RL23: memory model updates byte combinationally during write window.
`timescale 1ns/100ps
module asrc_host
    import asrc_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [AW-1:0] reqAddr,
    input wire logic [DW-1:0] reqData,
    output logic reqReady,
    output logic rspValid,
    output logic [DW-1:0] rspData,
    output logic [AW-1:0] wordAddress,
    output logic selectN,
    output logic strobeN,
    output logic driveEnN,
    input wire logic [DW-1:0] sharedByteBusIn,
    output logic [DW-1:0] sharedByteBusOut,
    output logic sharedByteBusOe
);
    import asrc_pkg::*;

    // ==========================================
    // sequencer
    asrc_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [DW-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic sel_q, sel_d, stb_q, stb_d, oe_q, oe_d, drv_q, drv_d;
    logic rdy_q, rdy_d, rvld_q, rvld_d;
    // spacing between memory cycles, counted from each request taken
    localparam int CYCLE_MIN_NS = (READ_CYCLE_MIN_NS > WRITE_CYCLE_MIN_NS) ?
        READ_CYCLE_MIN_NS : WRITE_CYCLE_MIN_NS;
    localparam logic [CNT_W-1:0] CYCLE_MIN_CYC = CNT_W'(cyc_up(CYCLE_MIN_NS));
    logic [CNT_W-1:0] span_q, span_d;
    logic take, spanMet;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        sel_d = sel_q;
        stb_d = stb_q;
        oe_d = oe_q;
        drv_d = drv_q;
        rdy_d = 1'b0;
        rvld_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // address only moves while select and strobe are high
                sel_d = 1'b1; // RL2 RL3 RL5
                stb_d = 1'b1;
                oe_d = 1'b1;
                drv_d = 1'b0;
                rdy_d = 1'b1;
                if (reqValid && rdy_q) begin
                    rdy_d = 1'b0;
                    addr_d = reqAddr; // RL13
                    wdat_d = reqData;
                    sel_d = 1'b0;
                    if (reqWrite) begin
                        // enable stays high, select leads: memory never drives
                        state_d = ST_WSEL; // RL7 RL9 RL10
                    end else begin
                        oe_d = 1'b0;
                        cnt_d = CNT_W'(READ_WAIT_CYC); // RL14 RL15 RL16
                        state_d = ST_RSEL;
                    end
                end
            end
            ST_RSEL: begin
                cnt_d = cnt_q - CNT_ONE;
                if (cnt_q == CNT_ONE) begin
                    rdat_d = sharedByteBusIn; // RL15
                    rvld_d = 1'b1;
                    sel_d = 1'b1;
                    oe_d = 1'b1;
                    // wait for the memory to float before any next cycle
                    cnt_d = CNT_W'(FLOAT_WAIT_CYC); // RL18 RL19
                    state_d = ST_GAP;
                end
            end
            ST_WSEL: begin
                stb_d = 1'b0; // RL4
                drv_d = 1'b1; // RL21
                cnt_d = CNT_W'(STROBE_CYC); // RL8 RL20
                state_d = ST_WSTB;
            end
            ST_WSTB: begin
                cnt_d = cnt_q - CNT_ONE;
                if (cnt_q == CNT_ONE) begin
                    // strobe rises first, ending the write
                    stb_d = 1'b1; // RL6 RL20
                    cnt_d = CNT_W'(HOLD_CYC);
                    state_d = ST_WHLD;
                end
            end
            ST_WHLD: begin
                cnt_d = cnt_q - CNT_ONE;
                if (cnt_q == CNT_ONE) begin
                    drv_d = 1'b0; // RL11 RL12
                    sel_d = 1'b1;
                    cnt_d = CNT_ONE;
                    state_d = ST_GAP;
                end
            end
            ST_GAP: begin
                cnt_d = cnt_q - CNT_ONE;
                if (cnt_q <= CNT_ONE) begin
                    cnt_d = CNT_ZERO;
                    if (spanMet) begin
                        rdy_d = 1'b1; // RL14
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
                sel_d = 1'b1;
                stb_d = 1'b1;
                oe_d = 1'b1;
                drv_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cnt_q <= CNT_ZERO;
            addr_q <= '0;
            wdat_q <= '0;
            rdat_q <= '0;
            sel_q <= 1'b1;
            stb_q <= 1'b1;
            oe_q <= 1'b1;
            drv_q <= 1'b0;
            rdy_q <= 1'b0;
            rvld_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            sel_q <= sel_d;
            stb_q <= stb_d;
            oe_q <= oe_d;
            drv_q <= drv_d;
            rdy_q <= rdy_d;
            rvld_q <= rvld_d;
        end
    end

    // ==========================================
    // cycle guard
    // at this clock the sequencer alone covers the minimum cycle;
    // a faster clock would not, so the gap also waits on this count
    assign take = (state_q == ST_IDLE) && reqValid && rdy_q;
    assign spanMet = (span_q >= CYCLE_MIN_CYC); // RL14

    always_comb begin
        span_d = span_q;
        if (take) begin
            span_d = CNT_ZERO;
        end else if (span_q != '1) begin
            // saturates so a long stall cannot wrap below the minimum
            span_d = span_q + CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            span_q <= CNT_ZERO;
        end else begin
            span_q <= span_d;
        end
    end

    // ==========================================
    // outputs
    // every pin comes straight from a register, so no glitch reaches the memory
    assign reqReady = rdy_q;
    assign rspValid = rvld_q;
    assign rspData = rdat_q;
    assign wordAddress = addr_q;
    assign selectN = sel_q;
    assign strobeN = stb_q;
    assign driveEnN = oe_q;
    assign sharedByteBusOut = wdat_q;
    assign sharedByteBusOe = drv_q;
endmodule

// ---- rtl/asrc_pkg.sv ----
// package: constants, timings and states for the async static memory host controller
package asrc_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int CLK_NS = 50;
    // fastest-grade timings, ns
    localparam int READ_CYCLE_MIN_NS = 15;
    localparam int ADDR_ACCESS_MAX_NS = 15;
    localparam int SELECT_ACCESS_MAX_NS = 15;
    localparam int DRIVE_ENABLE_ACCESS_NS = 10;
    localparam int DESELECT_TO_FLOAT_NS = 10;
    localparam int STROBE_TO_FLOAT_NS = 7;
    localparam int WRITE_CYCLE_MIN_NS = 15;
    localparam int SELECT_TO_END_MIN_NS = 13;
    localparam int ADDR_VALID_TO_END_MIN_NS = 14;
    localparam int STROBE_PULSE_MIN_NS = 12;
    localparam int DATA_OVERLAP_MIN_NS = 12;
    localparam int DATA_HOLD_AFTER_END_NS = 0;
    localparam int WRITE_RECOVERY_MIN_NS = 0;
    // least times round up, none below one cycle
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int READ_WAIT_NS = (SELECT_ACCESS_MAX_NS > ADDR_ACCESS_MAX_NS) ?
        SELECT_ACCESS_MAX_NS : ADDR_ACCESS_MAX_NS;
    localparam int READ_WAIT_CYC = cyc_up(READ_WAIT_NS);
    localparam int FLOAT_WAIT_CYC = cyc_up(DESELECT_TO_FLOAT_NS);
    localparam int STROBE_FLOAT_OVL_NS = STROBE_TO_FLOAT_NS + DATA_OVERLAP_MIN_NS;
    localparam int STROBE_NS = (STROBE_PULSE_MIN_NS > STROBE_FLOAT_OVL_NS) ?
        STROBE_PULSE_MIN_NS : STROBE_FLOAT_OVL_NS;
    localparam int STROBE_CYC = cyc_up(STROBE_NS);
    localparam int HOLD_CYC = cyc_up(DATA_HOLD_AFTER_END_NS);
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RSEL = 6'h02,
        ST_WSEL = 6'h04,
        ST_WSTB = 6'h08,
        ST_WHLD = 6'h10,
        ST_GAP = 6'h20
    } asrc_state_t;
endpackage

// ---- tb/asrc_host_monitor.sv ----
// checker: pin-order assertions for the static memory host controller
`timescale 1ns/100ps
module asrc_host_monitor (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire logic [asrc_pkg::ADDR_W-1:0] wordAddress,
    input wire logic selectN,
    input wire logic strobeN,
    input wire logic driveEnN,
    input wire logic [asrc_pkg::DATA_W-1:0] sharedByteBusOut,
    input wire logic sharedByteBusOe
);
    import asrc_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // ==========
    // transfer sequencing
    property p_take; reqValid && reqReady |=> !reqReady; endproperty
    a_take: assert property (p_take) else $error("ready held after take");
    property p_rd; reqValid && reqReady && !reqWrite |=> !selectN && !driveEnN && strobeN;
    endproperty
    a_rd: assert property (p_rd) else $error("read pins wrong");
    property p_rsp; reqValid && reqReady && !reqWrite |-> ##2 rspValid ##1 !rspValid;
    endproperty
    a_rsp: assert property (p_rsp) else $error("read answer late");
    // select leads the strobe and enable stays high, so the memory never drives during a write
    property p_wr; reqValid && reqReady && reqWrite |=>
        !selectN && strobeN ##1 !strobeN && driveEnN; endproperty
    a_wr: assert property (p_wr) else $error("write order wrong");
    property p_addr; !selectN && !strobeN |-> $stable(wordAddress) ##1 $stable(wordAddress);
    endproperty
    a_addr: assert property (p_addr) else $error("address moved in write");
    property p_clash; sharedByteBusOe |-> driveEnN; endproperty
    a_clash: assert property (p_clash) else $error("bus fight");
    property p_strb; !strobeN |-> sharedByteBusOe && !selectN; endproperty
    a_strb: assert property (p_strb) else $error("no data under strobe");
    property p_end; $rose(strobeN) |->
        !selectN && sharedByteBusOe && $stable(sharedByteBusOut); endproperty
    a_end: assert property (p_end) else $error("data not held");
endmodule
bind asrc_host asrc_host_monitor u_mon (.clk_sys, .sys_rst, .reqValid, .reqWrite, .reqReady,
    .rspValid, .wordAddress, .selectN, .strobeN, .driveEnN, .sharedByteBusOut,
    .sharedByteBusOe);

// ---- tb/asrc_mem_model.sv ----
// behavioural 2K x 8 asynchronous static memory
`timescale 1ns/100ps
module asrc_mem_model (
    input wire logic [asrc_pkg::ADDR_W-1:0] wordAddress,
    input wire logic selectN,
    input wire logic strobeN,
    input wire logic driveEnN,
    input wire logic [asrc_pkg::DATA_W-1:0] busIn,
    output logic [asrc_pkg::DATA_W-1:0] memOut,
    output logic memOe
);
    import asrc_pkg::*;
    logic [DATA_W-1:0] store [0:2047];
    // deselected means standby and a floating bus, whatever else is driven
    assign memOe = !selectN && !driveEnN && strobeN;
    assign memOut = store[wordAddress];
    always @* begin
        if (!selectN && !strobeN) begin
            store[wordAddress] = busIn;
        end
    end
endmodule

// ---- tb/asrc_host_tb.sv ----
// testbench: random and corner transfers through the host into a memory model
`timescale 1ns/100ps
module asrc_host_tb;
    import asrc_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic [ADDR_W-1:0] reqAddr = 11'h000;
    logic [DATA_W-1:0] reqData = 8'h00;
    logic [DATA_W-1:0] floatPat = 8'h5a;
    logic reqReady, rspValid, selectN, strobeN, driveEnN, sharedByteBusOe, memOe;
    logic [DATA_W-1:0] rspData, sharedByteBusOut, memOut, bus;
    logic [ADDR_W-1:0] wordAddress;
    logic [DATA_W-1:0] refMem [0:2047];
    int n_fail = 0;
    int n_compared = 0;
    always #25 clk_sys = ~clk_sys;
    // released bus shows a moving pattern so a stale byte cannot pass
    always @(posedge clk_sys) floatPat <= ~floatPat;
    assign bus = sharedByteBusOe ? sharedByteBusOut : (memOe ? memOut : floatPat);
    asrc_host DUT (.clk_sys, .sys_rst, .reqValid, .reqWrite, .reqAddr, .reqData, .reqReady,
        .rspValid, .rspData, .wordAddress, .selectN, .strobeN, .driveEnN,
        .sharedByteBusIn(bus), .sharedByteBusOut, .sharedByteBusOe);
    asrc_mem_model u_mem (.wordAddress, .selectN, .strobeN, .driveEnN, .busIn(bus),
        .memOut, .memOe);
    // ==========
    // tasks
    function automatic logic [7:0] expRead(input logic [10:0] a);
        return refMem[a];
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // request stands until taken or for at most 20 cycles; busy cycles in between are refused
    task automatic xfer(input logic w, input logic [10:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqAddr <= a;
        reqData <= d;
        do begin @(posedge clk_sys); n++; end while (reqReady !== 1'b1 && n < 20);
        reqValid <= 1'b0;
        if (n >= 20) n_fail++;
        if (w) refMem[a] = d;
        else begin
            // the answer stands for the one cycle after the edge that follows the taking edge
            @(posedge clk_sys);
            @(negedge clk_sys);
            check({7'h00, rspValid, rspData}, {8'h01, expRead(a)});
        end
    endtask
    // standby pins and no answer after reset, then ready one cycle later
    task automatic idle_check();
        logic [5:0] pins;
        @(negedge clk_sys);
        pins = {reqReady, rspValid, selectN, strobeN, driveEnN, sharedByteBusOe};
        check({10'h000, pins}, 16'h000e);
        @(negedge clk_sys);
        check({15'h0000, reqReady}, 16'h0001);
    endtask
    task automatic stop_test();
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #200_000;
        n_fail++;
        stop_test();
    end
    initial begin
        logic [10:0] a;
        logic [10:0] q[$];
        void'($urandom(59));
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        idle_check();
        // both ends of the array and a back-to-back overwrite
        xfer(1'b1, 11'h000, 8'hff);
        xfer(1'b1, 11'h7ff, 8'h00);
        xfer(1'b1, 11'h7ff, 8'ha5);
        xfer(1'b0, 11'h7ff, 8'h00);
        xfer(1'b0, 11'h000, 8'h00);
        repeat (24) begin
            a = 11'($urandom);
            q.push_back(a);
            xfer(1'b1, a, 8'($urandom));
            xfer(1'b0, a, 8'h00);
        end
        // reset in mid-read: no answer comes out and the pins fall back to standby
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqWrite <= 1'b0;
        reqAddr <= q[0];
        do @(posedge clk_sys); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        idle_check();
        foreach (q[i]) xfer(1'b0, q[i], 8'h00);
        stop_test();
    end
endmodule
